// *** hdl/acc_adc_ctrl.sv ***
module acc_adc_ctrl
(
  input  wire logic                                       core_clk,
  input  wire logic                                       sys_rst,
  input  wire logic                                       master_clock_in,
  input  wire logic [acc_pkg::NCH-1:0][acc_pkg::WORD_W-1:0] raw_sample,
  input  wire logic [acc_pkg::ADDR_W-1:0]                 reg_addr,
  input  wire logic [acc_pkg::REG_W-1:0]                  reg_wdata,
  input  wire logic                                       reg_wr,
  input  wire logic                                       reg_rd,
  output logic      [acc_pkg::REG_W-1:0]                  reg_rdata,
  input  wire logic                                       spi_sclk,
  input  wire logic                                       spi_cs_n,
  output logic                                            spi_sdo,
  output logic                                            spi_sdo_oe,
  output logic                                            sample_ready_n,
  output logic                                            irq,
  output logic                                            modulator_tick,
  output logic      [acc_pkg::NCH-1:0][acc_pkg::GAIN_W-1:0] pga_gain,
  output logic      [acc_pkg::NCH-1:0]                    channel_enable,
  output logic      [acc_pkg::CLK_MODE_W-1:0]             power_mode
);
  import acc_pkg::*;

  typedef struct packed {
    logic                              mclk_q;
    logic                              mod_phase;
    logic [OSR_CNT_W-1:0]              osr_cnt;
    logic                              push_pend;
    logic [REG_W-1:0]                  clock_cfg;
    logic [REG_W-1:0]                  gain_cfg;
    logic [NCH-1:0][REG_W-1:0]         ch_cfg;
    logic [NCH-1:0][REG_W-1:0]         ocal_up;
    logic [NCH-1:0][REG_W-1:0]         ocal_lo;
    logic [NCH-1:0][REG_W-1:0]         gcal_up;
    logic [NCH-1:0][REG_W-1:0]         gcal_lo;
    logic [IRQ_W-1:0]                  irq_status;
    logic [IRQ_W-1:0]                  irq_enable;
    logic [REG_W-1:0]                  rdata;
    logic [1:0][NCH-1:0][WORD_W-1:0]   fbuf;
    logic                              wr_ptr;
    logic                              rd_ptr;
    logic [1:0]                        count;
    logic                              ready_n;
    logic                              relow;
    logic                              sclk_q;
    logic                              cs_q;
    acc_spi_e                          spi_st;
    logic [FRAME_BITS-1:0]             shift;
    logic [BITCNT_W-1:0]               bitcnt;
    logic                              sdo;
  } acc_state_s;

  acc_state_s                st_r;
  acc_state_s                st_nxt;
  logic                      mclk_rise;
  logic                      mod_tick;
  logic                      sample_tick;
  logic [CLK_OSR_W-1:0]      osr_code;
  logic [OSR_CNT_W-1:0]      osr_last;
  logic [NCH-1:0]            capture;
  logic [NCH-1:0][WORD_W-1:0] result;
  logic                      sclk_rise;
  logic                      cs_fall;
  logic                      cs_rise;
  logic                      push;
  logic                      pop;
  logic                      full;
  logic [IRQ_W-1:0]          set_bits;
  logic [IRQ_W-1:0]          clr_bits;
  logic [NCH-1:0][WORD_W-1:0] frame;
  logic                      ch_hit;
  logic [CH_IDX_W-1:0]       ch_idx;
  logic [CH_KEY_W-1:0]       ch_key;

  // master clock is sampled as a plain level; fine up to half of core_clk
  assign mclk_rise   = master_clock_in & ~st_r.mclk_q;
  assign mod_tick    = mclk_rise & st_r.mod_phase;
  assign osr_code    = st_r.clock_cfg[CLK_OSR_LSB +: CLK_OSR_W];
  assign osr_last    = OSR_CNT_W'((OSR_BASE << osr_code) - 1);
  // at or past the end: a ratio lowered mid-frame must not run the counter round its full range
  assign sample_tick = mod_tick && (st_r.osr_cnt >= osr_last);
  assign sclk_rise   = spi_sclk & ~st_r.sclk_q;
  assign cs_fall     = ~spi_cs_n & st_r.cs_q;
  assign cs_rise     = spi_cs_n & ~st_r.cs_q;
  assign ch_hit      = reg_addr[ADDR_W-1:CH_REGION_LSB] == CH_REGION;
  assign ch_idx      = reg_addr[CH_IDX_LSB +: CH_IDX_W];
  assign ch_key      = reg_addr[CH_KEY_W-1:0];

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      // a phase delay at or past the frame length never captures; keep it below
      assign capture[gi] = mod_tick &&
        (st_r.osr_cnt == OSR_CNT_W'(st_r.ch_cfg[gi][PHASE_LSB +: PHASE_W]));
      acc_chan_corr u_corr
      (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .capture     (capture[gi]),
        .raw_in      (raw_sample[gi]),
        .mux_sel     (st_r.ch_cfg[gi][MUX_LSB +: MUX_W]),
        .dc_block_en (st_r.ch_cfg[gi][DC_EN_BIT]),
        .offset_cal  ({st_r.ocal_up[gi], st_r.ocal_lo[gi][CAL_LO_W-1:0]}),
        .gain_cal    ({st_r.gcal_up[gi], st_r.gcal_lo[gi][CAL_LO_W-1:0]}),
        .result      (result[gi])
      );
      assign pga_gain[gi] = st_r.gain_cfg[gi*GAIN_STRIDE +: GAIN_W];
    end
  endgenerate

  always_comb
  begin
    st_nxt   = st_r;
    set_bits = '0;
    pop      = 1'b0;
    st_nxt.mclk_q = master_clock_in;
    st_nxt.sclk_q = spi_sclk;
    st_nxt.cs_q   = spi_cs_n;
    if (mclk_rise)
      st_nxt.mod_phase = ~st_r.mod_phase;
    if (mod_tick)
      st_nxt.osr_cnt = sample_tick ? '0 : st_r.osr_cnt + 1'b1;
    // one cycle lag lets a capture on the last tick reach the frame
    st_nxt.push_pend = sample_tick;

    unique case (st_r.spi_st)
      ACC_SPI_IDLE:
        if (cs_fall)
        begin
          for (int k = 0; k < NCH; k++)
            st_nxt.shift[FRAME_BITS-1-k*WORD_W -: WORD_W] = st_r.fbuf[st_r.rd_ptr][k];
          st_nxt.bitcnt = '0;
          st_nxt.spi_st = ACC_SPI_SHIFT;
        end
      ACC_SPI_SHIFT:
        if (cs_rise)
          st_nxt.spi_st = ACC_SPI_IDLE;
        else if (sclk_rise)
        begin
          st_nxt.sdo    = st_r.shift[FRAME_BITS-1];
          st_nxt.shift  = {st_r.shift[FRAME_BITS-2:0], 1'b0};
          st_nxt.bitcnt = st_r.bitcnt + 1'b1;
          if (st_r.bitcnt == BITCNT_W'(FRAME_BITS - 1))
            st_nxt.spi_st = ACC_SPI_DONE;
        end
      ACC_SPI_DONE:
        if (cs_rise)
        begin
          pop = st_r.count != 2'h0;
          set_bits[IRQ_DONE] = 1'b1;
          st_nxt.spi_st = ACC_SPI_IDLE;
        end
    endcase

    push = st_r.push_pend;
    full = (st_r.count == 2'h2) && !pop;
    for (int k = 0; k < NCH; k++)
      frame[k] = st_r.clock_cfg[CLK_EN_LSB+k] ? result[k] : '0;
    if (push)
    begin
      set_bits[IRQ_READY] = 1'b1;
      if (full)
      begin
        // unread data: newest entry is overwritten, host sees stale frames
        st_nxt.fbuf[~st_r.wr_ptr] = frame;
        set_bits[IRQ_OVF] = 1'b1;
      end
      else
      begin
        st_nxt.fbuf[st_r.wr_ptr] = frame;
        st_nxt.wr_ptr = ~st_r.wr_ptr;
      end
    end
    if (pop)
      st_nxt.rd_ptr = ~st_r.rd_ptr;
    if (push && !full && !pop)
      st_nxt.count = st_r.count + 2'h1;
    else if (pop && !(push && !full))
      st_nxt.count = st_r.count - 2'h1;

    // a second frame while still low needs a high cycle to make a fresh edge
    if (push && !st_r.ready_n)
    begin
      st_nxt.ready_n = 1'b1;
      st_nxt.relow   = 1'b1;
    end
    else if (push || st_r.relow)
    begin
      st_nxt.ready_n = 1'b0;
      st_nxt.relow   = 1'b0;
    end
    else if (cs_fall)
      st_nxt.ready_n = 1'b1;

    clr_bits = (reg_wr && reg_addr == ADDR_IRQ_CLEAR) ? reg_wdata[IRQ_W-1:0] : '0;
    st_nxt.irq_status = (st_r.irq_status & ~clr_bits) | set_bits;

    if (reg_wr)
    begin
      if (reg_addr == ADDR_CLOCK_CFG)
        st_nxt.clock_cfg = reg_wdata;
      else if (reg_addr == ADDR_GAIN_CFG)
        st_nxt.gain_cfg = reg_wdata;
      else if (reg_addr == ADDR_IRQ_ENABLE)
        st_nxt.irq_enable = reg_wdata[IRQ_W-1:0];
      else if (ch_hit)
        unique case (ch_key)
          KEY_CFG:     st_nxt.ch_cfg[ch_idx]  = reg_wdata;
          KEY_OCAL_UP: st_nxt.ocal_up[ch_idx] = reg_wdata;
          KEY_OCAL_LO: st_nxt.ocal_lo[ch_idx] = {8'h00, reg_wdata[CAL_LO_W-1:0]};
          KEY_GCAL_UP: st_nxt.gcal_up[ch_idx] = reg_wdata;
          KEY_GCAL_LO: st_nxt.gcal_lo[ch_idx] = {8'h00, reg_wdata[CAL_LO_W-1:0]};
          default:     st_nxt.rdata = st_nxt.rdata;
        endcase
    end

    st_nxt.rdata = '0;
    if (reg_rd)
    begin
      if (reg_addr == ADDR_CLOCK_CFG)
        st_nxt.rdata = st_r.clock_cfg;
      else if (reg_addr == ADDR_GAIN_CFG)
        st_nxt.rdata = st_r.gain_cfg;
      else if (reg_addr == ADDR_IRQ_STATUS)
        st_nxt.rdata = {13'h0000, st_r.irq_status};
      else if (reg_addr == ADDR_IRQ_ENABLE)
        st_nxt.rdata = {13'h0000, st_r.irq_enable};
      else if (ch_hit)
        unique case (ch_key)
          KEY_CFG:     st_nxt.rdata = st_r.ch_cfg[ch_idx];
          KEY_OCAL_UP: st_nxt.rdata = st_r.ocal_up[ch_idx];
          KEY_OCAL_LO: st_nxt.rdata = st_r.ocal_lo[ch_idx];
          KEY_GCAL_UP: st_nxt.rdata = st_r.gcal_up[ch_idx];
          KEY_GCAL_LO: st_nxt.rdata = st_r.gcal_lo[ch_idx];
          default:     st_nxt.rdata = '0;
        endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r           <= '0;
      st_r.clock_cfg <= CLOCK_CFG_RST;
      st_r.gain_cfg  <= GAIN_CFG_RST;
      st_r.gcal_up   <= {NCH{GCAL_UP_RST}};
      st_r.ready_n   <= 1'b1;
      st_r.cs_q      <= 1'b1;
      st_r.spi_st    <= ACC_SPI_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  assign reg_rdata      = st_r.rdata;
  assign spi_sdo        = st_r.sdo;
  assign spi_sdo_oe     = st_r.spi_st != ACC_SPI_IDLE;
  assign sample_ready_n = st_r.ready_n;
  assign irq            = |(st_r.irq_status & st_r.irq_enable);
  assign modulator_tick = mod_tick;
  assign channel_enable = st_r.clock_cfg[CLK_EN_LSB +: NCH];
  assign power_mode     = st_r.clock_cfg[CLK_MODE_LSB +: CLK_MODE_W];

  // helper counters that only the checks below read
  logic [1:0]           h_rise;
  logic [OSR_CNT_W-1:0] h_mods;
  logic                 h_valid;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      h_rise  <= 2'h0;
      h_mods  <= '0;
      h_valid <= 1'b0;
    end
    else
    begin
      h_rise  <= mod_tick ? 2'h0 : (mclk_rise ? h_rise + 2'h1 : h_rise);
      h_mods  <= sample_tick ? '0 : (mod_tick ? h_mods + 1'b1 : h_mods);
      h_valid <= (reg_wr && reg_addr == ADDR_CLOCK_CFG) ? 1'b0 : (sample_tick ? 1'b1 : h_valid);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_mod_div;
    mclk_rise |-> (mod_tick == (h_rise == 2'h1));
  endproperty
  a_mod_div: assert property (p_mod_div) else $error("modulator tick not every second edge");

  property p_osr_rate;
    sample_tick && h_valid |-> h_mods == osr_last;
  endproperty
  a_osr_rate: assert property (p_osr_rate) else $error("frame spacing differs from ratio");

  sequence s_ready_fall;
    ##[1:2] $fell(sample_ready_n);
  endsequence
  property p_ready_edge;
    push |-> s_ready_fall;
  endproperty
  a_ready_edge: assert property (p_ready_edge) else $error("no ready falling edge after frame");

  property p_sdo_rise;
    $changed(spi_sdo) |-> $past(sclk_rise) && !$past(spi_cs_n);
  endproperty
  a_sdo_rise: assert property (p_sdo_rise) else $error("data changed off the rising clock");

  // the release edge still holds the state in reset, so an edge seen there is not followed
  property p_high_res_edge;
    !sys_rst && power_mode == MODE_HIGH_RES && mclk_rise |=> st_r.mod_phase != $past(st_r.mod_phase);
  endproperty
  a_high_res_edge: assert property (p_high_res_edge) else $error("master clock edge missed");

  property p_gain_wr;
    reg_wr && reg_addr == ADDR_GAIN_CFG |=> pga_gain[0] == $past(reg_wdata[GAIN_W-1:0]);
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("gain setting not applied");

  sequence s_clk_wr_rd;
    reg_wr && reg_addr == ADDR_CLOCK_CFG ##1 reg_rd && reg_addr == ADDR_CLOCK_CFG && !reg_wr;
  endsequence
  property p_clk_readback;
    s_clk_wr_rd |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_clk_readback: assert property (p_clk_readback) else $error("clock config readback wrong");

  property p_ovf;
    push && full |=> st_r.irq_status[IRQ_OVF] && st_r.count == 2'h2;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");
endmodule

// *** include/acc_pkg.sv ***
package acc_pkg;
  localparam int CORE_HZ    = 20_000_000;
  localparam int MCLK_HIGH_RES_HZ = 8_192_000;
  // the edge detector on the master clock needs core_clk above twice its rate
  localparam int MCLK_MIN_CORE_CYCLES = CORE_HZ / MCLK_HIGH_RES_HZ;
  localparam int NCH        = 4;
  localparam int WORD_W     = 24;
  localparam int REG_W      = 16;
  localparam int ADDR_W     = 8;
  localparam int CAL_LO_W   = 8;
  localparam int OSR_BASE   = 128;
  localparam int OSR_CNT_W  = 15;
  localparam int GCAL_FRAC  = 23;
  localparam int DC_FRAC    = 8;
  localparam int DC_SHIFT   = 6;
  localparam int DC_EST_W   = WORD_W + DC_FRAC;
  localparam int FRAME_BITS = NCH * WORD_W;
  localparam int BITCNT_W   = 7;

  localparam logic [ADDR_W-1:0] ADDR_CLOCK_CFG  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_CFG   = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR  = 8'h04;
  localparam int                CH_REGION_LSB   = 5;
  localparam logic [2:0]        CH_REGION       = 3'h1;
  localparam int                CH_IDX_LSB      = 3;
  localparam int                CH_IDX_W        = 2;
  localparam int                CH_KEY_W        = 3;
  localparam logic [2:0]        KEY_CFG         = 3'h0;
  localparam logic [2:0]        KEY_OCAL_UP     = 3'h1;
  localparam logic [2:0]        KEY_OCAL_LO     = 3'h2;
  localparam logic [2:0]        KEY_GCAL_UP     = 3'h3;
  localparam logic [2:0]        KEY_GCAL_LO     = 3'h4;

  localparam int CLK_MODE_LSB = 0;
  localparam int CLK_MODE_W   = 2;
  localparam int CLK_OSR_LSB  = 2;
  localparam int CLK_OSR_W    = 3;
  localparam int CLK_EN_LSB   = 8;
  localparam logic [1:0] MODE_HIGH_RES = 2'h2;
  localparam int GAIN_STRIDE  = 4;
  localparam int GAIN_W       = 3;
  localparam int MUX_LSB      = 0;
  localparam int MUX_W        = 2;
  localparam logic [1:0] MUX_EXT = 2'h0;
  localparam int DC_EN_BIT    = 2;
  localparam int PHASE_LSB    = 6;
  localparam int PHASE_W      = 10;

  localparam logic [REG_W-1:0]  CLOCK_CFG_RST = 16'h0f0a;
  localparam logic [REG_W-1:0]  GAIN_CFG_RST  = 16'h0000;
  localparam logic [REG_W-1:0]  GCAL_UP_RST   = 16'h8000;
  localparam logic [WORD_W-1:0] GCAL_UNITY    = 24'h800000;
  localparam logic [WORD_W-1:0] WORD_MAX      = 24'h7fffff;
  localparam logic [WORD_W-1:0] WORD_MIN      = 24'h800000;

  localparam int IRQ_W     = 3;
  localparam int IRQ_READY = 0;
  localparam int IRQ_OVF   = 1;
  localparam int IRQ_DONE  = 2;

  typedef enum logic [1:0] {ACC_SPI_IDLE, ACC_SPI_SHIFT, ACC_SPI_DONE} acc_spi_e;
endpackage

// *** hdl/acc_chan_corr.sv ***
module acc_chan_corr
(
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        capture,
  input  wire logic [acc_pkg::WORD_W-1:0]  raw_in,
  input  wire logic [acc_pkg::MUX_W-1:0]   mux_sel,
  input  wire logic                        dc_block_en,
  input  wire logic [acc_pkg::WORD_W-1:0]  offset_cal,
  input  wire logic [acc_pkg::WORD_W-1:0]  gain_cal,
  output logic      [acc_pkg::WORD_W-1:0]  result
);
  import acc_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0]   result;
    logic [DC_EST_W-1:0] dc_est;
  } acc_corr_s;

  acc_corr_s st_r;
  acc_corr_s st_nxt;
  logic signed [WORD_W-1:0]   x;
  logic signed [WORD_W-1:0]   sub;
  logic signed [WORD_W:0]     diff;
  logic signed [2*WORD_W+1:0] prod;
  logic signed [WORD_W+2:0]   scaled;
  logic signed [DC_EST_W-1:0] delta;
  logic                       sat_hi;
  logic                       sat_lo;

  always_comb
  begin
    st_nxt = st_r;
    x      = (mux_sel == MUX_EXT) ? raw_in : '0;
    // dc blocker estimate stands in for the programmed offset when enabled
    sub    = dc_block_en ? st_r.dc_est[DC_EST_W-1 -: WORD_W] : offset_cal;
    diff   = {x[WORD_W-1], x} - {sub[WORD_W-1], sub};
    prod   = diff * $signed({1'b0, gain_cal});
    scaled = prod[GCAL_FRAC +: WORD_W+3];
    sat_hi = !scaled[WORD_W+2] && (|scaled[WORD_W+1:WORD_W-1]);
    sat_lo = scaled[WORD_W+2] && !(&scaled[WORD_W+1:WORD_W-1]);
    delta  = $signed({x, {DC_FRAC{1'b0}}}) - $signed(st_r.dc_est);
    if (capture)
    begin
      st_nxt.result = sat_hi ? WORD_MAX : (sat_lo ? WORD_MIN : scaled[WORD_W-1:0]);
      st_nxt.dc_est = st_r.dc_est + DC_EST_W'(delta >>> DC_SHIFT);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign result = st_r.result;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_corr_hold;
    !capture |=> $stable(result);
  endproperty
  a_corr_hold: assert property (p_corr_hold) else $error("result moved without capture");

  property p_corr_unity;
    capture && !dc_block_en && mux_sel == MUX_EXT && gain_cal == GCAL_UNITY && offset_cal == '0
      |=> result == $past(raw_in);
  endproperty
  a_corr_unity: assert property (p_corr_unity) else $error("unity gain altered sample");
endmodule

// *** bench/acc_host_model.sv ***
module acc_host_model
(
  input  wire logic core_clk,
  output logic      master_clock_in,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  input  wire logic spi_sdo,
  input  wire logic spi_sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    master_clock_in = 1'b0;
    spi_sclk        = 1'b0;
    spi_cs_n        = 1'b1;
  end

  // free-running master clock, no phase relation to core_clk
  always #61.035 master_clock_in = ~master_clock_in;

  // shorter than a frame aborts the read; sclk high 3 cycles, low 2, so a frame fits one sample period
  task automatic read_frame(input int nbits, output logic [acc_pkg::FRAME_BITS-1:0] f);
    f = '0;
    @(posedge core_clk) spi_cs_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < nbits; i++)
    begin
      @(posedge core_clk) spi_sclk <= 1'b1;
      repeat (3) @(posedge core_clk);
      spi_sclk <= 1'b0;
      f = {f[acc_pkg::FRAME_BITS-2:0], spi_sdo};
      @(posedge core_clk);
    end
    @(posedge core_clk) spi_cs_n <= 1'b1;
  endtask
endmodule

// *** bench/acc_adc_ctrl_tb_top.sv ***
module acc_adc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import acc_pkg::*;
  logic                          core_clk, sys_rst, master_clock_in, spi_sclk, spi_cs_n;
  logic                          reg_wr, reg_rd, spi_sdo, spi_sdo_oe, sample_ready_n, irq, modulator_tick;
  logic [NCH-1:0][WORD_W-1:0]    raw_sample;
  logic [ADDR_W-1:0]             reg_addr;
  logic [REG_W-1:0]              reg_wdata, reg_rdata, gc, r;
  logic [NCH-1:0][GAIN_W-1:0]    pga_gain;
  logic [NCH-1:0]                channel_enable;
  logic [CLK_MODE_W-1:0]         power_mode;
  logic [WORD_W-1:0]             off [NCH];
  logic [WORD_W-1:0]             gn [NCH];
  logic [WORD_W-1:0]             x0, x1;
  logic [FRAME_BITS-1:0]         f;
  int                            n_mismatch, tests_run, cyc, n_rise, n_tick;
  real                           t_prev, t_last;

  acc_adc_ctrl dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .master_clock_in(master_clock_in),
    .raw_sample(raw_sample), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe), .sample_ready_n(sample_ready_n), .irq(irq), .modulator_tick(modulator_tick),
    .pga_gain(pga_gain), .channel_enable(channel_enable), .power_mode(power_mode));
  acc_host_model host_u (.core_clk(core_clk), .master_clock_in(master_clock_in), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge master_clock_in) n_rise++;
  always @(posedge core_clk) if (modulator_tick === 1'b1) n_tick++;
  always @(negedge sample_ready_n)
  begin
    t_prev = t_last;
    t_last = $realtime;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [WORD_W-1:0] corr(input logic [WORD_W-1:0] x, input logic [WORD_W-1:0] o,
                                             input logic [WORD_W-1:0] g);
    longint p;
    p = ((longint'(signed'(x)) - longint'(signed'(o))) * longint'(g)) >>> 23;
    if (p > 64'sh7fffff) return WORD_MAX;
    if (p < -64'sh800000) return WORD_MIN;
    return p[WORD_W-1:0];
  endfunction
  // ch2 has its input zeroed and the dc blocker on, whose estimate stays zero; ch3 is disabled
  function automatic logic [WORD_W-1:0] expw(input int n, input logic [WORD_W-1:0] x);
    if (n == 3) return '0;
    if (n == 2) return corr(24'h0, 24'h0, gn[2]);
    return corr(x, off[n], gn[n]);
  endfunction
  function automatic logic [ADDR_W-1:0] ca(input int n, input int k);
    return ADDR_W'(32'h20 + 8 * n + k);
  endfunction
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk) reg_rd <= 1'b0;
    @(negedge core_clk) d = reg_rdata;
  endtask
  task automatic rchk(input string w, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
    logic [REG_W-1:0] d;
    rd(a, d);
    check(w, d, e);
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    while (sample_ready_n !== 1'b0 && k < 3000)
    begin
      @(posedge core_clk);
      k++;
    end
    check("ready wait", k < 3000, 1);
  endtask

  initial
  begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, raw_sample} = '0;
    sys_rst = 1'b1;
    void'($urandom(32'h81181640));
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rchk("clock_config", ADDR_CLOCK_CFG, CLOCK_CFG_RST);
    rchk("gain_config", ADDR_GAIN_CFG, GAIN_CFG_RST);
    rchk("gain_cal_upper", ca(1, 3), GCAL_UP_RST);
    rchk("unmapped", 8'h10, 16'h0000);
    check("power_mode", power_mode, MODE_HIGH_RES);
    gc = 16'($urandom() & 32'h7777);
    wr(ADDR_GAIN_CFG, gc);
    rchk("gain_config", ADDR_GAIN_CFG, gc);
    for (int n = 0; n < NCH; n++)
    begin
      check("pga_gain", pga_gain[n], gc[4*n +: 3]);
      // ch3 runs at unity gain and zero offset so the unity check in its path gets exercised
      off[n] = (n == 3) ? 24'h0 : 24'($urandom_range(0, 32'h3ffff)) - 24'h20000;
      gn[n]  = (n == 3) ? GCAL_UNITY : 24'h600000 + 24'($urandom_range(0, 32'h3fffff));
      wr(ca(n, 0), n == 2 ? 16'h0005 : (n == 1 ? 16'h1900 : 16'h0000));
      wr(ca(n, 1), off[n][23:8]);
      wr(ca(n, 2), {8'h00, off[n][7:0]});
      wr(ca(n, 3), gn[n][23:8]);
      wr(ca(n, 4), {8'h00, gn[n][7:0]});
      rchk("offset_cal_lower", ca(n, 2), {8'h00, off[n][7:0]});
    end
    // write and read back with no gap between the strobes
    @(posedge core_clk);
    reg_addr  <= ADDR_CLOCK_CFG;
    reg_wdata <= 16'h0702;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk) reg_rd <= 1'b0;
    @(negedge core_clk) check("clock_config", reg_rdata, 16'h0702);
    check("channel_enable", channel_enable, 4'h7);
    wr(ADDR_IRQ_ENABLE, 16'h0001);
    x0 = 24'($urandom());
    x1 = 24'($urandom());
    raw_sample <= {NCH{x0}};
    n_rise = 0;
    n_tick = 0;
    repeat (1000) @(posedge core_clk);
    check("tick count", (n_rise - 2 * n_tick) inside {[-2:2]}, 1);
    repeat (2)
    begin
      wait_ready();
      host_u.read_frame(FRAME_BITS, f);
    end
    wait_ready();
    check("frame period", (t_last - t_prev) > 31140.0 && (t_last - t_prev) < 31360.0, 1);
    check("irq", irq, 1'b1);
    rd(ADDR_IRQ_STATUS, r);
    check("status ready", r[IRQ_READY], 1'b1);
    check("status done", r[IRQ_DONE], 1'b1);
    wr(ADDR_IRQ_CLEAR, 16'h0001);
    @(negedge core_clk) check("irq cleared", irq, 1'b0);
    // ch1 captures late in the frame, so only it sees the new input
    repeat (250) @(posedge core_clk);
    raw_sample <= {NCH{x1}};
    host_u.read_frame(16, f);
    host_u.read_frame(FRAME_BITS, f);
    for (int n = 0; n < NCH; n++)
      check("frame word", f[FRAME_BITS-1-WORD_W*n -: WORD_W], expw(n, x0));
    wait_ready();
    host_u.read_frame(FRAME_BITS, f);
    check("sdo_oe busy", spi_sdo_oe, 1'b1);
    for (int n = 0; n < NCH; n++)
      check("phased word", f[FRAME_BITS-1-WORD_W*n -: WORD_W], expw(n, n == 1 ? x1 : x0));
    wr(ADDR_IRQ_ENABLE, 16'h0002);
    check("sdo_oe idle", spi_sdo_oe, 1'b0);
    repeat (2000) @(posedge core_clk);
    check("overflow irq", irq, 1'b1);
    rd(ADDR_IRQ_STATUS, r);
    check("status overflow", r[IRQ_OVF], 1'b1);
    wr(ADDR_IRQ_ENABLE, 16'h0000);
    @(negedge core_clk) check("irq masked", irq, 1'b0);
    stop_test();
  end
endmodule
